// ===== design/acph_consts.vh
`ifndef ACPH_CONSTS_VH
`define ACPH_CONSTS_VH

// Bus status codes (3 lines)
`define ACPH_CODE_SOP      3'h0
`define ACPH_CODE_IOP      3'h2
`define ACPH_CODE_FETCH    3'h4
`define ACPH_CODE_STATUS   3'h1
`define ACPH_CODE_GM       3'h3
`define ACPH_CODE_WSPACE   3'h6
`define ACPH_CODE_IACK     3'h5
`define ACPH_CODE_WP       3'h7
`define ACPH_CODE_MID      3'h0
`define ACPH_CODE_GRANT    3'h7
`define ACPH_CODE_IDLE     3'h3

// Status word fields
`define ACPH_SW_EXTOP_EN   11
`define ACPH_SW_CLR_BIT    8
`define ACPH_SW_RESET      16'h0000

// Workspace words and trap vector
`define ACPH_WP_RESET      16'h0000
`define ACPH_PC_RESET      16'h0000
`define ACPH_TRAP2_ADDR    16'h0008
`define ACPH_SAVE_WP_OFS   16'h001a
`define ACPH_SAVE_PC_OFS   16'h001c
`define ACPH_SAVE_SW_OFS   16'h001e

// Opcode classes
`define ACPH_EXTOP_MASK    16'hfc00
`define ACPH_EXTOP_VAL     16'h2c00

// Cycles before a synchronised pin may be trusted
`define ACPH_SYNC_LAG      3'h4

// Clock divider for the system clock output
`define ACPH_CLK_DIV       2'h1

`endif

// ===== design/acph_sync3.v
`timescale 1ns/1ps
`default_nettype none

module acph_sync3 (
    // Clock and reset
    input  wire ref_clk,
    input  wire rstn,
    // Pin in, filtered level out
    input  wire pin,
    output reg  level
);

    reg s1;
    reg s2;
    reg s3;

    // Change counts once stage two and three agree
    always @(posedge ref_clk) begin
        if (!rstn) begin
            s1    <= 1'b1;
            s2    <= 1'b1;
            s3    <= 1'b1;
            level <= 1'b1;
        end else begin
            s1 <= pin;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3) begin
                level <= s3;
            end
        end
    end

endmodule

`default_nettype wire

// ===== design/acph_opdecode.v
`timescale 1ns/1ps
`default_nettype none
`include "acph_consts.vh"

module acph_opdecode (
    // Opcode and mode
    input  wire [15:0] opcode,
    input  wire        extop_as_mid,
    input  wire        known_op,
    // Classification
    output wire        is_mid
);

    wire is_extop;

    assign is_extop = ((opcode & `ACPH_EXTOP_MASK) == `ACPH_EXTOP_VAL);
    // Extended ops go out as unknown when mode bit set
    assign is_mid = !known_op || (is_extop && extop_as_mid);

endmodule

`default_nettype wire

// ===== design/acph_handoff.v
`timescale 1ns/1ps
`default_nettype none
`include "acph_consts.vh"

module acph_handoff (
    // Clock and reset
    input  wire        ref_clk,
    input  wire        rstn,
    // Fetch request from the instruction sequencer
    input  wire        fetch_req,
    input  wire [15:0] fetch_addr,
    input  wire        known_op,
    // Pins in
    input  wire        coproc_present_n,
    input  wire        hold_req_n,
    input  wire        ready,
    input  wire        present_tied_low,
    input  wire [15:0] ad_in,
    // Bus outputs
    output reg  [2:0]  bus_status_lines,
    output reg  [2:0]  bus_status_oe_n,
    output reg         mem_n,
    output reg         rd_n,
    output reg         we_n,
    output reg         strobe_oe_n,
    output reg         addr_latch_strobe,
    output reg         addr_latch_oe_n,
    output reg  [15:0] ad_out,
    output reg         ad_oe_n,
    output reg         page_select,
    output reg         system_clock_out,
    // Sequencer answers
    output reg         fetch_done,
    output reg  [15:0] fetch_opcode,
    output reg         emulate_start,
    output reg         illegal_op_interrupt,
    output reg         in_hold,
    output reg  [15:0] status_word,
    output reg  [15:0] wp,
    output reg  [15:0] pc
);

    // ------------------------------------------------------------
    // States
    // ------------------------------------------------------------
    localparam S_IDLE   = 4'h0;
    localparam S_FETCH  = 4'h1;
    localparam S_MID    = 4'h2;
    localparam S_SAMPLE = 4'h3;
    localparam S_STOUT  = 4'h4;
    localparam S_VECT   = 4'h5;
    localparam S_WPOUT  = 4'h6;
    localparam S_SAVE   = 4'h7;
    localparam S_HDRV   = 4'h8;
    localparam S_HOLD   = 4'h9;
    localparam S_LOAD   = 4'ha;

    reg  [3:0]  state;
    reg  [3:0]  next_state;
    reg  [1:0]  word_idx;
    reg  [2:0]  wait_cnt;
    reg  [15:0] new_wp;
    reg  [15:0] old_wp;
    reg  [15:0] old_pc;
    reg  [15:0] old_sw;
    reg  [1:0]  clk_div;
    wire        present_n;
    wire        ready_s;
    wire        is_mid;
    wire        settled;
    wire        bus_go;
    wire        mem_start;
    wire        cyc_start;
    wire [1:0]  start_idx;
    wire [15:0] save_val;
    wire [15:0] save_ofs;

    acph_sync3 u_sync_present (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .pin     (coproc_present_n),
        .level   (present_n)
    );

    acph_sync3 u_sync_ready (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .pin     (ready),
        .level   (ready_s)
    );

    acph_opdecode u_dec (
        .opcode       (ad_in),
        .extop_as_mid (status_word[`ACPH_SW_EXTOP_EN]),
        .known_op     (known_op),
        .is_mid       (is_mid)
    );

    // Synchronised pins lag; a cycle trusts them only after the lag
    assign settled   = (wait_cnt == `ACPH_SYNC_LAG);
    assign bus_go    = settled && ready_s;
    assign start_idx = (state == next_state) ? word_idx + 2'h1 : 2'h0;
    assign mem_start = ((next_state == S_FETCH) && (state == S_IDLE)) ||
                       ((next_state == S_VECT) && (state != S_VECT)) ||
                       ((next_state == S_SAVE) && ((state != S_SAVE) || bus_go)) ||
                       ((next_state == S_LOAD) && ((state != S_LOAD) || bus_go));
    assign cyc_start = mem_start || ((next_state != state) &&
                       ((next_state == S_SAMPLE) || (next_state == S_STOUT) ||
                        (next_state == S_WPOUT)));
    assign save_val  = (word_idx == 2'h0) ? old_wp :
                       (word_idx == 2'h1) ? old_pc : old_sw;
    assign save_ofs  = (start_idx == 2'h0) ? `ACPH_SAVE_WP_OFS :
                       (start_idx == 2'h1) ? `ACPH_SAVE_PC_OFS : `ACPH_SAVE_SW_OFS;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always @* begin
        next_state = state;
        case (state)
            S_IDLE:   if (fetch_req) next_state = S_FETCH;
            // Fetch, status, vector, pointer, save and load cycles wait on ready
            S_FETCH:  if (bus_go) next_state = is_mid ? S_MID : S_IDLE;
            S_MID:    next_state = S_SAMPLE;
            S_SAMPLE: begin
                if (settled) begin
                    next_state = (!present_n && !present_tied_low) ? S_STOUT : S_IDLE;
                end
            end
            S_STOUT:  if (bus_go) next_state = S_VECT;
            S_VECT:   if (bus_go) next_state = S_WPOUT;
            S_WPOUT:  if (bus_go) next_state = S_SAVE;
            S_SAVE:   if (bus_go && word_idx == 2'h2) next_state = S_HDRV;
            S_HDRV:   next_state = S_HOLD;
            S_HOLD:   if (present_n) next_state = S_LOAD;
            S_LOAD:   if (bus_go && word_idx == 2'h2) next_state = S_IDLE;
            default:  next_state = S_IDLE;
        endcase
    end

    // ------------------------------------------------------------
    // Sequencer and context
    // ------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (!rstn) begin
            state                <= S_IDLE;
            word_idx             <= 2'h0;
            wait_cnt             <= 3'h0;
            new_wp               <= `ACPH_WP_RESET;
            old_wp               <= `ACPH_WP_RESET;
            old_pc               <= `ACPH_PC_RESET;
            old_sw               <= `ACPH_SW_RESET;
            wp                   <= `ACPH_WP_RESET;
            pc                   <= `ACPH_PC_RESET;
            status_word          <= `ACPH_SW_RESET;
            fetch_done           <= 1'b0;
            fetch_opcode         <= 16'h0000;
            emulate_start        <= 1'b0;
            illegal_op_interrupt <= 1'b0;
            in_hold              <= 1'b0;
        end else begin
            state                <= next_state;
            if (cyc_start) begin
                wait_cnt <= 3'h0;
            end else if (!settled) begin
                wait_cnt <= wait_cnt + 3'h1;
            end
            fetch_done           <= 1'b0;
            emulate_start        <= 1'b0;
            illegal_op_interrupt <= 1'b0;
            case (state)
                S_IDLE: begin
                    if (fetch_req) begin
                        pc <= fetch_addr;
                    end
                end
                S_FETCH: begin
                    if (bus_go) begin
                        fetch_opcode <= ad_in;
                        fetch_done   <= !is_mid;
                        // Counter left at the word after the opcode
                        pc           <= pc + 16'h0002;
                    end
                end
                S_SAMPLE: begin
                    if (settled && present_tied_low) begin
                        illegal_op_interrupt <= 1'b1;
                    end else if (settled && present_n) begin
                        emulate_start <= 1'b1;
                    end else if (settled) begin
                        old_wp      <= wp;
                        old_pc      <= pc;
                        old_sw      <= status_word;
                        status_word <= status_word & ~(16'h0001 << `ACPH_SW_CLR_BIT);
                    end
                end
                S_VECT: begin
                    if (bus_go) begin
                        new_wp <= ad_in;
                    end
                end
                S_WPOUT: begin
                    if (bus_go) begin
                        wp       <= new_wp;
                        word_idx <= 2'h0;
                    end
                end
                S_SAVE: begin
                    if (bus_go) begin
                        word_idx <= (word_idx == 2'h2) ? 2'h0 : word_idx + 2'h1;
                    end
                end
                S_HOLD: begin
                    in_hold <= !present_n;
                end
                S_LOAD: begin
                    if (bus_go) begin
                        // Reload from saved words 13, 14, 15
                        case (word_idx)
                            2'h0:    wp          <= ad_in;
                            2'h1:    pc          <= ad_in;
                            default: status_word <= ad_in;
                        endcase
                        word_idx <= (word_idx == 2'h2) ? 2'h0 : word_idx + 2'h1;
                    end
                end
                default: begin
                end
            endcase
            if (next_state == S_HOLD) begin
                in_hold <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Bus pins
    // ------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (!rstn) begin
            bus_status_lines  <= `ACPH_CODE_IDLE;
            bus_status_oe_n   <= 3'h0;
            mem_n             <= 1'b1;
            rd_n              <= 1'b1;
            we_n              <= 1'b1;
            strobe_oe_n       <= 1'b0;
            addr_latch_strobe <= 1'b0;
            addr_latch_oe_n   <= 1'b0;
            ad_out            <= 16'h0000;
            ad_oe_n           <= 1'b1;
            page_select       <= 1'b0;
        end else begin
            bus_status_oe_n   <= 3'h0;
            strobe_oe_n       <= 1'b0;
            addr_latch_oe_n   <= 1'b0;
            addr_latch_strobe <= 1'b0;
            mem_n             <= 1'b1;
            rd_n              <= 1'b1;
            we_n              <= 1'b1;
            ad_oe_n           <= 1'b1;
            page_select       <= 1'b0;
            case (next_state)
                S_FETCH: begin
                    bus_status_lines  <= `ACPH_CODE_FETCH;
                    mem_n             <= 1'b0;
                    rd_n              <= 1'b0;
                    // Address phase is latched, then the lines float for data
                    addr_latch_strobe <= mem_start;
                    ad_oe_n           <= !mem_start;
                    ad_out            <= mem_start ? fetch_addr : ad_out;
                end
                S_MID: begin
                    bus_status_lines <= `ACPH_CODE_MID;
                end
                S_STOUT: begin
                    bus_status_lines <= `ACPH_CODE_STATUS;
                    ad_out           <= status_word;
                    ad_oe_n          <= 1'b0;
                end
                S_VECT: begin
                    bus_status_lines  <= `ACPH_CODE_IACK;
                    page_select       <= 1'b1;
                    mem_n             <= 1'b0;
                    rd_n              <= 1'b0;
                    addr_latch_strobe <= mem_start;
                    ad_oe_n           <= !mem_start;
                    ad_out            <= `ACPH_TRAP2_ADDR;
                end
                S_WPOUT: begin
                    bus_status_lines <= `ACPH_CODE_WP;
                    ad_out           <= new_wp;
                    ad_oe_n          <= 1'b0;
                end
                S_SAVE: begin
                    bus_status_lines  <= `ACPH_CODE_WSPACE;
                    mem_n             <= 1'b0;
                    // Write strobe held off during the address phase
                    we_n              <= mem_start;
                    addr_latch_strobe <= mem_start;
                    ad_out            <= mem_start ? new_wp + save_ofs : save_val;
                    ad_oe_n           <= 1'b0;
                end
                S_HDRV: begin
                    // Drive high one cycle before floating
                    bus_status_lines  <= `ACPH_CODE_GRANT;
                    addr_latch_strobe <= 1'b1;
                    ad_oe_n           <= 1'b1;
                end
                S_HOLD: begin
                    bus_status_lines  <= `ACPH_CODE_GRANT;
                    bus_status_oe_n   <= 3'h7;
                    strobe_oe_n       <= 1'b1;
                    addr_latch_strobe <= 1'b1;
                    addr_latch_oe_n   <= 1'b1;
                end
                S_LOAD: begin
                    // New pointer kept, since wp is reloaded mid sequence
                    bus_status_lines  <= `ACPH_CODE_WSPACE;
                    mem_n             <= 1'b0;
                    rd_n              <= 1'b0;
                    addr_latch_strobe <= mem_start;
                    ad_oe_n           <= !mem_start;
                    ad_out            <= mem_start ? new_wp + save_ofs : ad_out;
                end
                default: begin
                    bus_status_lines <= `ACPH_CODE_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // System clock out, never gated by hold
    // ------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (!rstn) begin
            clk_div          <= 2'h0;
            system_clock_out <= 1'b0;
        end else if (clk_div == `ACPH_CLK_DIV) begin
            clk_div          <= 2'h0;
            system_clock_out <= !system_clock_out;
        end else begin
            clk_div <= clk_div + 2'h1;
        end
    end

endmodule

`default_nettype wire

// ===== bench/acph_checker.sv
`timescale 1ns/1ps
`default_nettype none
`include "acph_consts.vh"

module acph_checker (
    // Clock and reset
    input wire logic        ref_clk,
    input wire logic        rstn,
    // Pins
    input wire logic        coproc_present_n,
    input wire logic        present_tied_low,
    input wire logic [2:0]  bus_status_lines,
    input wire logic [2:0]  bus_status_oe_n,
    input wire logic        mem_n,
    input wire logic        rd_n,
    input wire logic        we_n,
    input wire logic        strobe_oe_n,
    input wire logic        addr_latch_strobe,
    input wire logic        addr_latch_oe_n,
    input wire logic [15:0] ad_out,
    input wire logic        ad_oe_n,
    input wire logic        page_select,
    input wire logic        system_clock_out,
    // Sequencer side
    input wire logic        fetch_done,
    input wire logic        emulate_start,
    input wire logic        in_hold,
    input wire logic [15:0] status_word
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    property p_fetch_code;
        fetch_done |-> $past(bus_status_lines) == `ACPH_CODE_FETCH;
    endproperty
    a_fetch_code: assert property (p_fetch_code)
        else $error("fetch finished without opcode fetch code");

    property p_page;
        page_select |-> bus_status_lines == `ACPH_CODE_IACK;
    endproperty
    a_page: assert property (p_page)
        else $error("page select outside vector fetch");

    property p_hold_float;
        $rose(&bus_status_oe_n) |-> $past(bus_status_lines) == `ACPH_CODE_GRANT;
    endproperty
    a_hold_float: assert property (p_hold_float)
        else $error("status lines floated without hold code");

    property p_strobe_float;
        $rose(strobe_oe_n) |-> $past(mem_n & rd_n & we_n);
    endproperty
    a_strobe_float: assert property (p_strobe_float)
        else $error("strobes floated while active");

    property p_latch_float;
        $rose(addr_latch_oe_n) |-> $past(addr_latch_strobe);
    endproperty
    a_latch_float: assert property (p_latch_float)
        else $error("latch strobe floated while low");

    property p_ad_float;
        $rose(ad_oe_n) |-> ad_out == $past(ad_out);
    endproperty
    a_ad_float: assert property (p_ad_float)
        else $error("data lines changed on release");

    property p_clk_runs;
        $past(rstn, 3) |-> system_clock_out != $past(system_clock_out, 2);
    endproperty
    a_clk_runs: assert property (p_clk_runs)
        else $error("clock output stalled");

    property p_clr8;
        $rose(in_hold) |-> !status_word[`ACPH_SW_CLR_BIT];
    endproperty
    a_clr8: assert property (p_clr8)
        else $error("status bit 8 set in hold");

    property p_release;
        (in_hold && coproc_present_n) [*4] |-> ##[0:6] !in_hold;
    endproperty
    a_release: assert property (p_release)
        else $error("hold kept after present released");

    property p_resume;
        $fell(in_hold) |-> ##[0:2] bus_status_lines == `ACPH_CODE_WSPACE;
    endproperty
    a_resume: assert property (p_resume)
        else $error("no workspace code on resume");

    property p_emul;
        emulate_start |-> !present_tied_low;
    endproperty
    a_emul: assert property (p_emul)
        else $error("emulation while present strapped low");
endmodule

bind acph_handoff acph_checker i_chk (.ref_clk, .rstn, .coproc_present_n, .present_tied_low,
    .bus_status_lines, .bus_status_oe_n, .mem_n, .rd_n, .we_n, .strobe_oe_n,
    .addr_latch_strobe, .addr_latch_oe_n, .ad_out, .ad_oe_n, .page_select,
    .system_clock_out, .fetch_done, .emulate_start, .in_hold, .status_word);
`default_nettype wire

// ===== bench/acph_coproc.sv
`timescale 1ns/1ps
`default_nettype none
`include "acph_consts.vh"

module acph_coproc (
    // Clock
    input wire logic        ref_clk,
    // Processor bus
    input wire logic [2:0]  bus_status_lines,
    input wire logic [2:0]  bus_status_oe_n,
    input wire logic        mem_n,
    input wire logic        rd_n,
    input wire logic        we_n,
    input wire logic        strobe_oe_n,
    input wire logic        addr_latch_strobe,
    input wire logic        addr_latch_oe_n,
    input wire logic [15:0] ad_out,
    // Bench controls
    input wire logic        accept,
    input wire logic [3:0]  waits,
    input wire logic [7:0]  hold_len,
    // Answers
    output logic            coproc_present_n,
    output logic            hold_req_n,
    output logic            ready,
    output logic [15:0]     ad_in
);
    logic [15:0] mem [0:63];
    logic [15:0] addr;
    logic [15:0] op_seen;
    logic [15:0] last = 16'h0000;
    logic [2:0]  prev = 3'h3;
    logic [3:0]  wcnt = 4'h0;
    logic [7:0]  hcnt = 8'h00;
    logic        claim = 1'b0;
    wire         rd_now = !mem_n && !rd_n && !strobe_oe_n;
    wire         code_on = (bus_status_oe_n == 3'h0);
    wire         floated = &bus_status_oe_n;

    assign hold_req_n = 1'b1;
    assign coproc_present_n = !claim;
    // Wait states counted from each address latch
    assign ready = mem_n || (!addr_latch_strobe && wcnt >= waits);
    // Released data lines never repeat the last word
    assign ad_in = rd_now ? mem[addr[6:1]] : ~last;

    always @(posedge ref_clk) begin
        prev <= code_on ? bus_status_lines : 3'h3;
        wcnt <= addr_latch_strobe ? 4'h0 : wcnt + {3'h0, wcnt != 4'hf};
        if (addr_latch_strobe && !addr_latch_oe_n)
            addr <= ad_out;
        if (rd_now)
            last <= ad_in;
        if (!we_n && !strobe_oe_n)
            mem[addr[6:1]] <= ad_out;
        if (rd_now && code_on && bus_status_lines == `ACPH_CODE_FETCH)
            op_seen <= ad_in;
        if (accept && code_on && prev == `ACPH_CODE_FETCH && bus_status_lines == `ACPH_CODE_MID)
            claim <= 1'b1;
        hcnt <= (claim && floated) ? hcnt + 8'h01 : 8'h00;
        // Never drives the bus, so it is free to let go once counted
        if (claim && floated && hcnt == hold_len)
            claim <= 1'b0;
    end
endmodule
`default_nettype wire

// ===== bench/tb_attached_coprocessor_handoff.sv
`timescale 1ns/1ps
`default_nettype none

module tb_attached_coprocessor_handoff;
    logic        ref_clk = 1'b0;
    logic        rstn, fetch_req, known_op, present_tied_low, accept;
    logic [15:0] fetch_addr;
    logic [3:0]  waits;
    logic [7:0]  hold_len;
    logic        coproc_present_n, hold_req_n, ready;
    logic [15:0] ad_in, ad_out, fetch_opcode, status_word, wp, pc;
    logic [2:0]  bus_status_lines, bus_status_oe_n;
    logic        mem_n, rd_n, we_n, strobe_oe_n, addr_latch_strobe, addr_latch_oe_n;
    logic        ad_oe_n, page_select, system_clock_out, fetch_done, emulate_start;
    logic        illegal_op_interrupt, in_hold;
    logic [3:0]  seen;
    logic [15:0] sav [0:2];
    int          fail_count = 0;
    int          total_checks = 0;
    int          cycles = 0;

    acph_handoff i_dut (.ref_clk, .rstn, .fetch_req, .fetch_addr, .known_op,
        .coproc_present_n, .hold_req_n, .ready, .present_tied_low, .ad_in,
        .bus_status_lines, .bus_status_oe_n, .mem_n, .rd_n, .we_n, .strobe_oe_n,
        .addr_latch_strobe, .addr_latch_oe_n, .ad_out, .ad_oe_n, .page_select,
        .system_clock_out, .fetch_done, .fetch_opcode, .emulate_start,
        .illegal_op_interrupt, .in_hold, .status_word, .wp, .pc);

    acph_coproc i_cop (.ref_clk, .bus_status_lines, .bus_status_oe_n, .mem_n, .rd_n,
        .we_n, .strobe_oe_n, .addr_latch_strobe, .addr_latch_oe_n, .ad_out, .accept,
        .waits, .hold_len, .coproc_present_n, .hold_req_n, .ready, .ad_in);

    initial begin
        forever #50 ref_clk = ~ref_clk;
    end

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, got, exp);
        end
    endtask

    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // One fetch, then watch; words saved in hold are captured and the
    // coprocessor's results are written back while it owns the bus
    task automatic do_fetch(input logic [15:0] a, input logic k);
        seen = 4'h0;
        fetch_addr = a;
        known_op = k;
        fetch_req = 1'b1;
        @(negedge ref_clk) fetch_req = 1'b0;
        repeat (300) begin
            @(negedge ref_clk);
            if (in_hold === 1'b1 && !seen[0]) begin
                for (int i = 0; i < 3; i++)
                    sav[i] = i_cop.mem[45 + i];
                i_cop.mem[46] = 16'h0030;
                i_cop.mem[47] = 16'h0900;
            end
            seen |= {fetch_done, emulate_start, illegal_op_interrupt, in_hold};
        end
    endtask

    task automatic t_known;
        do_fetch(16'h0010, 1'b1);
        check({12'h000, seen}, 16'h0008);
        check(fetch_opcode, 16'h1234);
        check(i_cop.op_seen, 16'h1234);
        $display("test known_fetch done");
    endtask

    task automatic t_emulate;
        do_fetch(16'h0012, 1'b0);
        check({12'h000, seen}, 16'h0004);
        $display("test emulate done");
    endtask

    task automatic t_handoff;
        accept = 1'b1;
        do_fetch(16'h0020, 1'b0);
        check({12'h000, seen}, 16'h0001);
        check(sav[0], 16'h0000);
        check(sav[1], 16'h0022);
        check(sav[2] & 16'hfeff, 16'h0000);
        check(wp, 16'h0000);
        check(pc, 16'h0030);
        check(status_word, 16'h0900);
        $display("test handoff done");
    endtask

    task automatic t_xop;
        do_fetch(16'h0024, 1'b1);
        check({12'h000, seen}, 16'h0001);
        check(sav[1], 16'h0026);
        check(sav[2], 16'h0900);
        check({15'h0000, in_hold}, 16'h0000);
        check(status_word, 16'h0900);
        $display("test xop_handoff done");
    endtask

    task automatic t_illegal;
        accept = 1'b0;
        present_tied_low = 1'b1;
        do_fetch(16'h0028, 1'b0);
        check({12'h000, seen}, 16'h0002);
        $display("test illegal_op done");
    endtask

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            $display("[FAIL] %0t run did not finish", $time);
            complete_run;
        end
    end

    initial begin
        rstn = 1'b0;
        fetch_req = 1'b0;
        known_op = 1'b1;
        present_tied_low = 1'b0;
        accept = 1'b0;
        fetch_addr = 16'h0000;
        waits = 4'h2;
        hold_len = 8'd20;
        for (int i = 0; i < 64; i++)
            i_cop.mem[i] = 16'h0000;
        i_cop.mem[4] = 16'h0040;
        i_cop.mem[8] = 16'h1234;
        i_cop.mem[9] = 16'h0c01;
        i_cop.mem[16] = 16'h0c02;
        i_cop.mem[18] = 16'h2c05;
        i_cop.mem[20] = 16'h0c03;
        repeat (5) @(negedge ref_clk);
        rstn = 1'b1;
        t_known;
        t_emulate;
        t_handoff;
        t_xop;
        t_illegal;
        complete_run;
    end
endmodule
`default_nettype wire
